// ==== logic/e1h_host_ctrl.sv ====
// Host controller that drives an E1 framer through its system-side pins.
//
// Overview of operation
// - Frame holds 32 slots, slot 0 first.
// - Each slot goes out MSB first.
// - Drive receive sync only with elastic store.
// - Backplane clock held low unless store enabled.
// - Transmit data stable at clock falling edge.
// - Link bits sampled on transmit clock fall.
// - Transmit sync pulse sets frame boundary.
// - Bus strap picks strobe style.
// - Address latched from shared bus strobe.
// - Chip select low for whole access.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module e1h_host_ctrl (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	// Software register port
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWdata,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic [7:0]      regRdata,
	// Device host port
	output logic            chip_select_n,
	output logic            address_capture_strobe,
	output logic            read_or_data_strobe,
	output logic            write_or_rw_strobe,
	output logic [7:0]      shared_addr_data_bus_out,
	output logic            shared_addr_data_bus_oe,
	input  wire logic [7:0] shared_addr_data_bus_in,
	input  wire logic       bus_style_strap,
	input  wire logic       alarm_irq_first_n,
	input  wire logic       alarm_irq_second_n,
	// Device receive side
	input  wire logic       rx_recovered_clock,
	input  wire logic       rx_serial_out,
	input  wire logic       rx_boundary_pulse_in,
	output logic            rx_boundary_pulse_out,
	output logic            rx_boundary_pulse_oe,
	input  wire logic       rx_slot_clock,
	input  wire logic       rx_slot_gate,
	input  wire logic       rx_sa_demand_clock,
	input  wire logic       rx_sa_link_data,
	input  wire logic       sync_loss_or_tx_clock_loss,
	output logic            backplane_clock,
	// Device transmit side
	output logic            tx_line_clock,
	output logic            tx_serial_in,
	input  wire logic       tx_boundary_pulse_in,
	output logic            tx_boundary_pulse_out,
	output logic            tx_boundary_pulse_oe,
	input  wire logic       tx_slot_clock,
	input  wire logic       tx_slot_gate,
	input  wire logic       tx_sa_demand_clock,
	output logic            tx_sa_link_data
);
	// Two-stage synchronisers for every pin coming from the device.
	localparam int NSYNC = 13;
	logic [NSYNC-1:0] pinRaw;
	logic [NSYNC-1:0] pinMeta;
	logic [NSYNC-1:0] pinSync;
	assign pinRaw = {bus_style_strap, alarm_irq_first_n, alarm_irq_second_n,
		rx_recovered_clock, rx_serial_out, rx_boundary_pulse_in, rx_slot_clock,
		rx_slot_gate, rx_sa_demand_clock, rx_sa_link_data,
		sync_loss_or_tx_clock_loss, tx_slot_gate, tx_sa_demand_clock};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge sys_clk) begin
				pinMeta[gi] <= pinRaw[gi];
				pinSync[gi] <= pinMeta[gi];
			end
		end
	endgenerate

	wire busStyleS  = pinSync[12];
	wire irqFirstS  = pinSync[11];
	wire irqSecondS = pinSync[10];
	wire rxClkS     = pinSync[9];
	wire rxDataS    = pinSync[8];
	wire rxSyncS    = pinSync[7];
	wire rxSlotClkS = pinSync[6];
	wire rxGateS    = pinSync[5];
	wire rxDemandS  = pinSync[4];
	wire rxLinkS    = pinSync[3];
	wire alarmS     = pinSync[2];
	wire txGateS    = pinSync[1];
	wire txDemandS  = pinSync[0];

	// Slower-changing pins: txSyncS reaches a status bit, txSlotS only reaches rxSlotSeen.
	logic txSyncMeta;
	logic txSyncS;
	logic txSlotMeta;
	logic txSlotS;
	always_ff @(posedge sys_clk) begin
		txSyncMeta <= tx_boundary_pulse_in;
		txSyncS    <= txSyncMeta;
		txSlotMeta <= tx_slot_clock;
		txSlotS    <= txSlotMeta;
	end

	// Software registers.
	logic [7:0] ctrl_reg;
	logic [7:0] devAddr_reg;
	logic [7:0] devWdata_reg;
	logic [7:0] txLink_reg;
	logic [7:0] rxLink_reg;
	logic       rxLocked_reg;
	logic       devStart_reg;
	logic       devRead_reg;
	logic [7:0] txMem [0:e1h_pkg::SLOTS_PER_FRAME-1];
	logic [7:0] rxMem [0:e1h_pkg::SLOTS_PER_FRAME-1];

	wire       txEn      = ctrl_reg[e1h_pkg::CTRL_TX_EN];
	wire       txSyncDrv = ctrl_reg[e1h_pkg::CTRL_TX_SYNC_DRV];
	wire       elastic   = ctrl_reg[e1h_pkg::CTRL_ELASTIC];
	wire       rxSyncDrv = ctrl_reg[e1h_pkg::CTRL_RX_SYNC_DRV];
	wire       txLinkEn  = ctrl_reg[e1h_pkg::CTRL_TX_LINK_EN];
	wire [4:0] slotIdx   = regAddr[4:0];
	wire       selTxSlot = (regAddr[7:5] == e1h_pkg::REG_TX_SLOT_HI);
	wire       selRxSlot = (regAddr[7:5] == e1h_pkg::REG_RX_SLOT_HI);
	wire       wrCtrl    = regWr && (regAddr == e1h_pkg::REG_CTRL);
	wire       wrAddr    = regWr && (regAddr == e1h_pkg::REG_DEV_ADDR);
	wire       wrWdata   = regWr && (regAddr == e1h_pkg::REG_DEV_WDATA);
	wire       wrCmd     = regWr && (regAddr == e1h_pkg::REG_DEV_CMD);
	wire       wrTxLink  = regWr && (regAddr == e1h_pkg::REG_TX_LINK);
	wire       wrTxSlot  = regWr && selTxSlot;

	logic       devBusy;
	logic [7:0] devRdata;
	wire  [7:0] status = {txSyncS, txGateS, rxGateS, !irqSecondS, !irqFirstS,
		alarmS, rxLocked_reg, devBusy};

	logic [7:0] rdMux;
	always_comb begin
		rdMux = 8'h00;
		case (regAddr)
			e1h_pkg::REG_CTRL:      rdMux = ctrl_reg;
			e1h_pkg::REG_STATUS:    rdMux = status;
			e1h_pkg::REG_DEV_ADDR:  rdMux = devAddr_reg;
			e1h_pkg::REG_DEV_WDATA: rdMux = devWdata_reg;
			e1h_pkg::REG_DEV_RDATA: rdMux = devRdata;
			e1h_pkg::REG_TX_LINK:   rdMux = txLink_reg;
			e1h_pkg::REG_RX_LINK:   rdMux = rxLink_reg;
			default: begin
				if (selTxSlot)
					rdMux = txMem[slotIdx];
				else if (selRxSlot)
					rdMux = rxMem[slotIdx];
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			regRdata     <= 8'h00;
			ctrl_reg     <= e1h_pkg::CTRL_RESET;
			devAddr_reg  <= 8'h00;
			devWdata_reg <= 8'h00;
			devStart_reg <= 1'b0;
			devRead_reg  <= 1'b0;
		end else begin
			regRdata     <= regRd ? rdMux : 8'h00;
			devStart_reg <= wrCmd && !devBusy;
			if (wrCtrl)
				ctrl_reg <= regWdata;
			if (wrAddr)
				devAddr_reg <= regWdata;
			if (wrWdata)
				devWdata_reg <= regWdata;
			if (wrCmd)
				devRead_reg <= regWdata[e1h_pkg::CMD_READ];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (wrTxSlot)
			txMem[slotIdx] <= regWdata;
	end

	// Host port bus cycles.
	e1h_mpu_port u_port (
		.sys_clk    (sys_clk),
		.sys_rst    (sys_rst),
		.start      (devStart_reg),
		.isRead     (devRead_reg),
		.addr       (devAddr_reg),
		.wdata      (devWdata_reg),
		.busStyle   (busStyleS),
		.busy       (devBusy),
		.rdata      (devRdata),
		.chipSelN   (chip_select_n),
		.addrStrobe (address_capture_strobe),
		.rdDsStrobe (read_or_data_strobe),
		.wrRwStrobe (write_or_rw_strobe),
		.adOut      (shared_addr_data_bus_out),
		.adOe       (shared_addr_data_bus_oe),
		.adIn       (shared_addr_data_bus_in)
	);

	// Generated line clock, 24 system clocks per period (about 2.083MHz); it also serves as backplane clock when the store is on.
	logic [4:0] div_reg;
	logic [7:0] txBit_reg;
	logic       lineClk_reg;
	wire        divWrap = (div_reg == e1h_pkg::LINE_HALF - 5'h1);
	wire        txRise  = divWrap && !lineClk_reg;
	wire        txFall  = divWrap && lineClk_reg;
	wire [7:0]  txBitNext = txBit_reg + 8'h01;
	wire [7:0]  txByte  = txMem[txBitNext[7:3]];

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			div_reg               <= 5'h00;
			lineClk_reg           <= 1'b0;
			txBit_reg             <= 8'hFF;
			tx_line_clock         <= 1'b0;
			backplane_clock       <= 1'b0;
			tx_serial_in          <= 1'b0;
			tx_boundary_pulse_out <= 1'b0;
			tx_boundary_pulse_oe  <= 1'b0;
			rx_boundary_pulse_out <= 1'b0;
			rx_boundary_pulse_oe  <= 1'b0;
			tx_sa_link_data       <= 1'b0;
			txLink_reg            <= e1h_pkg::TX_LINK_RESET;
		end else begin
			div_reg         <= divWrap ? 5'h00 : div_reg + 5'h01;
			if (divWrap)
				lineClk_reg <= !lineClk_reg;
			tx_line_clock   <= lineClk_reg;
			backplane_clock <= elastic && lineClk_reg;
			tx_boundary_pulse_oe <= txSyncDrv && txEn;
			rx_boundary_pulse_oe <= elastic && rxSyncDrv;
			// New bits go out on the rising edge, so they are settled at the fall.
			if (txRise && txEn) begin
				txBit_reg             <= txBitNext;
				tx_serial_in          <= txByte[3'h7 - txBitNext[2:0]];
				tx_boundary_pulse_out <= (txBitNext == e1h_pkg::FRAME_FIRST_BIT);
				rx_boundary_pulse_out <= (txBitNext == e1h_pkg::FRAME_FIRST_BIT);
			end else if (!txEn) begin
				// A pulse cut by disabling must not stay high for good.
				tx_boundary_pulse_out <= 1'b0;
				rx_boundary_pulse_out <= 1'b0;
			end
			if (wrTxLink)
				txLink_reg <= regWdata;
			else if (txRise && txLinkEn && txDemandS) begin
				tx_sa_link_data <= txLink_reg[7];
				txLink_reg      <= {txLink_reg[6:0], txLink_reg[7]};
			end
		end
	end

	// Receive capture. With the store on, data follow our own backplane clock only while transmit is enabled.
	logic rxClkPrev;
	logic rxDemPrev;
	logic [7:0] rxBit_reg;
	logic [6:0] rxShift_reg;
	wire  rxFallDev  = rxClkPrev && !rxClkS;
	wire  rxSample   = elastic ? (txFall && txEn) : rxFallDev;
	wire  [7:0] rxCur = rxSyncS ? e1h_pkg::FRAME_FIRST_BIT : rxBit_reg + 8'h01;
	wire  rxByteEnd  = (rxCur[2:0] == e1h_pkg::SLOT_LAST_BIT);
	wire  rxDemRise  = rxDemandS && !rxDemPrev;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rxClkPrev    <= 1'b0;
			rxDemPrev    <= 1'b0;
			rxBit_reg    <= 8'hFF;
			rxShift_reg  <= 7'h00;
			rxLocked_reg <= 1'b0;
			rxLink_reg   <= 8'h00;
		end else begin
			rxClkPrev <= rxClkS;
			rxDemPrev <= rxDemandS;
			if (rxSample) begin
				rxBit_reg   <= rxCur;
				rxShift_reg <= {rxShift_reg[5:0], rxDataS};
				if (rxSyncS)
					rxLocked_reg <= 1'b1;
				else if (wrCtrl)
					rxLocked_reg <= 1'b0;
			end else if (wrCtrl)
				rxLocked_reg <= 1'b0;
			if (rxDemRise)
				rxLink_reg <= {rxLink_reg[6:0], rxLinkS};
		end
	end

	// The slot clock and LSB position agree; the bit count closes the byte.
	always_ff @(posedge sys_clk) begin
		if (rxSample && rxByteEnd)
			rxMem[rxCur[7:3]] <= {rxShift_reg, rxDataS};
	end

	// Slot clock is unused by capture; it only sets rxSlotSeen, which no output or status bit reads.
	logic rxSlotSeen;
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			rxSlotSeen <= 1'b0;
		else
			rxSlotSeen <= rxSlotClkS | txSlotS;
	end
endmodule : e1h_host_ctrl

// ==== logic/e1h_pkg.sv ====
// Shared constants for the E1 framer host controller.
package e1h_pkg;
	localparam int SYS_CLK_HZ  = 50000000;
	localparam int LINE_CLK_HZ = 2048000;
	// Half period, in system clocks, of the 2.048MHz target, rounded down to 12.
	localparam int LINE_HALF_CYC = SYS_CLK_HZ / (2 * LINE_CLK_HZ);
	localparam logic [4:0] LINE_HALF = 5'(LINE_HALF_CYC);
	localparam int SLOTS_PER_FRAME = 32;
	localparam int BITS_PER_SLOT = 8;
	localparam logic [2:0] SLOT_LAST_BIT = 3'h7;
	localparam logic [7:0] FRAME_FIRST_BIT = 8'h00;
	// Last phase count of a host port phase; each phase lasts this plus one system clocks.
	localparam logic [2:0] HP_PHASE_CYC = 3'h4;
	// Software register map, byte addresses.
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_STATUS    = 8'h01;
	localparam logic [7:0] REG_DEV_ADDR  = 8'h02;
	localparam logic [7:0] REG_DEV_WDATA = 8'h03;
	localparam logic [7:0] REG_DEV_CMD   = 8'h04;
	localparam logic [7:0] REG_DEV_RDATA = 8'h05;
	localparam logic [7:0] REG_TX_LINK   = 8'h06;
	localparam logic [7:0] REG_RX_LINK   = 8'h07;
	localparam logic [2:0] REG_TX_SLOT_HI = 3'h1;
	localparam logic [2:0] REG_RX_SLOT_HI = 3'h2;
	localparam logic [7:0] CTRL_RESET    = 8'h00;
	localparam logic [7:0] TX_LINK_RESET = 8'h00;
	// Control bit positions.
	localparam int CTRL_TX_EN      = 0;
	localparam int CTRL_TX_SYNC_DRV = 1;
	localparam int CTRL_ELASTIC    = 2;
	localparam int CTRL_RX_SYNC_DRV = 3;
	localparam int CTRL_TX_LINK_EN = 4;
	localparam int CMD_READ = 0;
endpackage : e1h_pkg

// ==== logic/e1h_mpu_port.sv ====
// Multiplexed 8-bit host port master with selectable strobe style.
`timescale 1ns/10ps
module e1h_mpu_port (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	// Command side
	input  wire logic       start,
	input  wire logic       isRead,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       busStyle,
	output logic            busy,
	output logic [7:0]      rdata,
	// Device pins
	output logic            chipSelN,
	output logic            addrStrobe,
	output logic            rdDsStrobe,
	output logic            wrRwStrobe,
	output logic [7:0]      adOut,
	output logic            adOe,
	input  wire logic [7:0] adIn
);
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_LATCH = 3'b010,
		ST_STRB  = 3'b011,
		ST_END   = 3'b100
	} e1h_hp_state_t;

	e1h_hp_state_t state_reg;
	e1h_hp_state_t state_next;
	logic [2:0]    phase_reg;
	logic          rd_reg;
	logic [7:0]    adMeta;
	logic [7:0]    adSync;
	wire           phaseDone = (phase_reg == e1h_pkg::HP_PHASE_CYC);
	wire           inStrb    = (state_reg == e1h_hp_state_t'(ST_STRB));

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:  if (start) state_next = ST_ADDR;
			ST_ADDR:  if (phaseDone) state_next = ST_LATCH;
			ST_LATCH: if (phaseDone) state_next = ST_STRB;
			ST_STRB:  if (phaseDone) state_next = ST_END;
			ST_END:   if (phaseDone) state_next = ST_IDLE;
			default:  state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		adMeta <= adIn;
		adSync <= adMeta;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_reg  <= ST_IDLE;
			phase_reg  <= 3'h0;
			rd_reg     <= 1'b0;
			busy       <= 1'b0;
			rdata      <= 8'h00;
			chipSelN   <= 1'b1;
			addrStrobe <= 1'b0;
			rdDsStrobe <= 1'b1;
			wrRwStrobe <= 1'b1;
			adOut      <= 8'h00;
			adOe       <= 1'b0;
		end else begin
			state_reg <= state_next;
			phase_reg <= (state_next != state_reg) ? 3'h0 : phase_reg + 3'h1;
			if (state_reg == ST_IDLE && start)
				rd_reg <= isRead;
			busy       <= (state_next != ST_IDLE);
			chipSelN   <= (state_next == ST_IDLE);
			addrStrobe <= (state_next == ST_ADDR);
			adOe       <= (state_next == ST_ADDR) || (state_next == ST_LATCH)
				|| (state_next == ST_STRB && !rd_reg);
			adOut      <= (state_next == ST_STRB) ? wdata : addr;
			if (busStyle) begin
				rdDsStrobe <= (state_next == ST_STRB);
				wrRwStrobe <= rd_reg || (state_next != ST_STRB);
			end else begin
				rdDsStrobe <= !(state_next == ST_STRB && rd_reg);
				wrRwStrobe <= !(state_next == ST_STRB && !rd_reg);
			end
			if (inStrb && phaseDone && rd_reg)
				rdata <= adSync;
		end
	end
endmodule : e1h_mpu_port

// ==== verif/e1h_host_ctrl_asserts.sv ====
// Port-level checks for the E1 framer host controller.
`timescale 1ns/10ps
module e1h_host_ctrl_asserts (
	input wire logic       sys_clk, sys_rst, regWr, chip_select_n, address_capture_strobe,
	input wire logic [7:0] regAddr, regWdata, shared_addr_data_bus_out,
	input wire logic       shared_addr_data_bus_oe, rx_boundary_pulse_oe, backplane_clock,
	input wire logic       tx_line_clock, tx_serial_in, tx_boundary_pulse_out
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	logic [7:0] ctrlSeen;
	logic [3:0] ctrlAge;
	// Control bits pass through registers, so the pins may lag a write by a few cycles.
	always_ff @(posedge sys_clk) begin
		if (sys_rst || (regWr && regAddr == e1h_pkg::REG_CTRL)) begin
			ctrlSeen <= sys_rst ? e1h_pkg::CTRL_RESET : regWdata;
			ctrlAge  <= 4'h0;
		end else if (ctrlAge != 4'hF) begin
			ctrlAge <= ctrlAge + 4'h1;
		end
	end
	a_reset_idle: assert property ($past(sys_rst) |-> chip_select_n && !shared_addr_data_bus_oe)
		else $error("port active after reset");
	a_ale_in_cs: assert property (address_capture_strobe |-> !chip_select_n && shared_addr_data_bus_oe)
		else $error("address strobe outside access");
	a_ale_length: assert property ($rose(address_capture_strobe) |->
		address_capture_strobe[*5] ##1 !address_capture_strobe)
		else $error("address phase length");
	a_addr_steady: assert property (address_capture_strobe && $past(address_capture_strobe) |->
		$stable(shared_addr_data_bus_out))
		else $error("address moved in address phase");
	a_cs_whole: assert property ($fell(chip_select_n) |-> !chip_select_n[*8] ##[10:14] chip_select_n)
		else $error("chip select span");
	a_rx_sync_drive: assert property (ctrlAge > 4'h4 && rx_boundary_pulse_oe |->
		ctrlSeen[e1h_pkg::CTRL_ELASTIC] && ctrlSeen[e1h_pkg::CTRL_RX_SYNC_DRV])
		else $error("rx sync driven without store");
	a_backplane_low: assert property (ctrlAge > 4'h4 && !ctrlSeen[e1h_pkg::CTRL_ELASTIC] |->
		!backplane_clock)
		else $error("backplane clock not held low");
	a_tx_data_hold: assert property ($fell(tx_line_clock) |->
		$stable(tx_serial_in) ##1 $stable(tx_serial_in))
		else $error("tx data moved at clock fall");
	a_tx_pulse_one: assert property ($rose(tx_boundary_pulse_out) |->
		tx_boundary_pulse_out[*8] ##[14:18] !tx_boundary_pulse_out)
		else $error("tx sync pulse width");
	cover property ($rose(address_capture_strobe));
	cover property ($rose(rx_boundary_pulse_oe));
	cover property ($rose(tx_boundary_pulse_out));
endmodule : e1h_host_ctrl_asserts
bind e1h_host_ctrl e1h_host_ctrl_asserts u_e1h_host_ctrl_asserts (.sys_clk, .sys_rst, .regWr,
	.chip_select_n, .address_capture_strobe, .regAddr, .regWdata, .shared_addr_data_bus_out,
	.shared_addr_data_bus_oe, .rx_boundary_pulse_oe, .backplane_clock, .tx_line_clock,
	.tx_serial_in, .tx_boundary_pulse_out);

// ==== verif/e1h_dev_model.sv ====
// Behavioural model of the E1 framer as seen from its system-side pins.
`timescale 1ns/10ps
module e1h_dev_model (
	// Host port
	input  wire logic       sys_clk, chip_select_n, address_capture_strobe, bus_style_strap,
	input  wire logic       read_or_data_strobe, write_or_rw_strobe, shared_addr_data_bus_oe,
	input  wire logic [7:0] shared_addr_data_bus_out,
	output logic      [7:0] shared_addr_data_bus_in,
	output logic            alarm_irq_first_n, alarm_irq_second_n, sync_loss_or_tx_clock_loss,
	// Receive side
	input  wire logic       rx_boundary_pulse_out, rx_boundary_pulse_oe, backplane_clock,
	output logic            rx_recovered_clock, rx_serial_out, rx_boundary_pulse_in,
	output logic            rx_slot_clock, rx_slot_gate, rx_sa_demand_clock, rx_sa_link_data,
	// Transmit side
	input  wire logic       tx_line_clock, tx_serial_in, tx_boundary_pulse_out,
	input  wire logic       tx_boundary_pulse_oe, tx_sa_link_data,
	output logic            tx_boundary_pulse_in, tx_slot_clock, tx_slot_gate, tx_sa_demand_clock
);
	logic [7:0] mem [256];
	logic [7:0] txSlot [32];
	logic [7:0] devAddr, wrLatch, rxByte, lastBus = 8'h00, txSh = 8'h00, linkSh = 8'h00;
	logic [7:0] rxIdx = 8'h00, txIdx = 8'h00;
	logic       wrPrev = 1'b0, rdOn, wrOn;
	initial for (int i = 0; i < 256; i++) mem[i] = 8'h00;
	initial rx_recovered_clock = 1'b0;
	always #80 rx_recovered_clock = ~rx_recovered_clock;
	assign rdOn = !chip_select_n && (bus_style_strap ? read_or_data_strobe && write_or_rw_strobe
		: !read_or_data_strobe);
	assign wrOn = !chip_select_n && (bus_style_strap ? read_or_data_strobe && !write_or_rw_strobe
		: !write_or_rw_strobe);
	// A released bus flips every cycle, so a stale read cannot match by luck.
	assign shared_addr_data_bus_in = shared_addr_data_bus_oe ? shared_addr_data_bus_out
		: rdOn ? mem[devAddr] : ~lastBus;
	always @(posedge sys_clk) begin
		lastBus <= shared_addr_data_bus_in;
		wrPrev  <= wrOn;
		if (address_capture_strobe && !chip_select_n) devAddr <= shared_addr_data_bus_in;
		if (wrOn) wrLatch <= shared_addr_data_bus_in;
		if (wrPrev && !wrOn) mem[devAddr] <= wrLatch;
	end
	assign alarm_irq_first_n          = (mem[8'h06] == 8'h00);
	assign alarm_irq_second_n         = (mem[8'h07] == 8'h00);
	assign sync_loss_or_tx_clock_loss = 1'b0;
	always @(posedge rx_recovered_clock) rxIdx <= rxIdx + 8'h01;
	assign rxByte               = 8'hC3 ^ {3'h0, rxIdx[7:3]};
	assign rx_serial_out        = rxByte[3'h7 - rxIdx[2:0]];
	assign rx_boundary_pulse_in = rx_boundary_pulse_oe ? rx_boundary_pulse_out : (rxIdx == 8'h00);
	assign rx_slot_clock        = (rxIdx[2:0] == 3'h7);
	assign rx_slot_gate         = (rxIdx[7:3] > 5'h03);
	assign rx_sa_demand_clock   = (rxIdx[7:3] == 5'h00) && (rxIdx[2:0] > 3'h2);
	assign rx_sa_link_data      = rx_serial_out;
	always @(negedge tx_line_clock) begin
		// Link bits are taken only while the demand clock for the current bit is high.
		if (tx_sa_demand_clock) linkSh = {linkSh[6:0], tx_sa_link_data};
		txIdx = (tx_boundary_pulse_oe && tx_boundary_pulse_out) ? 8'h00 : txIdx + 8'h01;
		txSh = {txSh[6:0], tx_serial_in};
		if (txIdx[2:0] == 3'h7) txSlot[txIdx[7:3]] = txSh;
	end
	assign tx_boundary_pulse_in = tx_boundary_pulse_oe ? tx_boundary_pulse_out : (txIdx == 8'h00);
	assign tx_slot_clock        = (txIdx[2:0] == 3'h7);
	assign tx_slot_gate         = (txIdx[7:3] > 5'h03);
	assign tx_sa_demand_clock   = (txIdx[7:3] == 5'h00) && (txIdx[2:0] > 3'h2);
endmodule : e1h_dev_model

// ==== verif/test_e1h_host_ctrl.sv ====
// Self-checking bench for the E1 framer host controller.
`timescale 1ns/10ps
module test_e1h_host_ctrl;
	logic sys_clk = 1'b0, sys_rst = 1'b1, regWr = 1'b0, regRd = 1'b0, bus_style_strap = 1'b0;
	logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, shared_addr_data_bus_out, rd;
	logic [7:0] shared_addr_data_bus_in;
	logic chip_select_n, address_capture_strobe, read_or_data_strobe, write_or_rw_strobe;
	logic shared_addr_data_bus_oe, alarm_irq_first_n, alarm_irq_second_n, backplane_clock;
	logic rx_recovered_clock, rx_serial_out, rx_boundary_pulse_in, rx_boundary_pulse_out;
	logic rx_boundary_pulse_oe, rx_slot_clock, rx_slot_gate, rx_sa_demand_clock, rx_sa_link_data;
	logic sync_loss_or_tx_clock_loss, tx_line_clock, tx_serial_in, tx_boundary_pulse_in;
	logic tx_boundary_pulse_out, tx_boundary_pulse_oe, tx_slot_clock, tx_slot_gate;
	logic tx_sa_demand_clock, tx_sa_link_data;
	int mismatches = 0;
	int cmp_count = 0;
	e1h_host_ctrl u_e1h_host_ctrl (.*);
	e1h_dev_model u_e1h_dev_model (.*);
	always #10 sys_clk = ~sys_clk;
	task automatic chk(input logic [7:0] exp, input logic [7:0] got, input string what);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s: %h not %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regWr    <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		@(posedge sys_clk);
		regRd   <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 rd = regRdata;
	endtask : rdr
	task automatic dev(input logic [7:0] a, input logic [7:0] d, input logic isRd);
		int n;
		wr(e1h_pkg::REG_DEV_ADDR, a);
		wr(e1h_pkg::REG_DEV_WDATA, d);
		wr(e1h_pkg::REG_DEV_CMD, {7'h00, isRd});
		n = 0;
		rd = 8'h01;
		while (rd[0] !== 1'b0 && n < 60) begin
			rdr(e1h_pkg::REG_STATUS);
			n++;
		end
		chk(8'h00, rd & 8'h01, "port idle");
		rdr(e1h_pkg::REG_DEV_RDATA);
	endtask : dev
	task automatic tPort();
		rdr(e1h_pkg::REG_CTRL);
		chk(e1h_pkg::CTRL_RESET, rd, "ctrl reset");
		rdr(8'h1F);
		chk(8'h00, rd, "unmapped");
		for (int s = 0; s < 2; s++) begin
			bus_style_strap <= s[0];
			repeat (4) @(posedge sys_clk);
			dev(8'h20 + 8'(s), 8'hA5 ^ 8'(s), 1'b0);
			chk(8'hA5 ^ 8'(s), u_e1h_dev_model.mem[8'h20 + 8'(s)], "dev write");
			dev(8'h20 + 8'(s), 8'h00, 1'b1);
			chk(8'hA5 ^ 8'(s), rd, "dev read");
		end
		dev(8'h06, 8'h01, 1'b0);
		rdr(e1h_pkg::REG_STATUS);
		chk(8'h08, rd & 8'h18, "irq one");
		dev(8'h06, 8'h00, 1'b0);
		dev(8'h07, 8'h40, 1'b0);
		rdr(e1h_pkg::REG_STATUS);
		chk(8'h10, rd & 8'h18, "irq two");
		$display("port test done");
	endtask : tPort
	task automatic tStream();
		for (int i = 0; i < 32; i++) wr(8'h20 + 8'(i), 8'h96 ^ 8'(i));
		wr(e1h_pkg::REG_TX_LINK, 8'hFF);
		wr(e1h_pkg::REG_CTRL, 8'h13);
		repeat (13000) @(posedge sys_clk);
		for (int i = 0; i < 32; i++) chk(8'h96 ^ 8'(i), u_e1h_dev_model.txSlot[i], "tx");
		chk(8'hFF, u_e1h_dev_model.linkSh, "tx link");
		wr(e1h_pkg::REG_CTRL, 8'h00);
		repeat (4200) @(posedge sys_clk);
		for (int i = 0; i < 32; i++) begin
			rdr(8'h40 + 8'(i));
			chk(8'hC3 ^ 8'(i), rd, "rx");
		end
		rdr(e1h_pkg::REG_STATUS);
		chk(8'h02, rd & 8'h02, "rx lock");
		$display("stream test done");
	endtask : tStream
	task automatic tStore();
		wr(e1h_pkg::REG_CTRL, 8'h0C);
		repeat (10) @(posedge sys_clk);
		#1 chk(8'h01, {7'h00, rx_boundary_pulse_oe}, "sync drive");
		wr(e1h_pkg::REG_CTRL, 8'h08);
		repeat (10) @(posedge sys_clk);
		#1 chk(8'h00, {7'h00, rx_boundary_pulse_oe}, "sync no store");
		chk(8'h00, {7'h00, backplane_clock}, "backplane low");
		$display("store test done");
	endtask : tStore
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude
	initial begin
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'b0;
		tPort();
		tStream();
		tStore();
		conclude();
	end
	initial begin
		repeat (60000) @(posedge sys_clk);
		mismatches++;
		conclude();
	end
endmodule : test_e1h_host_ctrl
